//--- hdl/pau_pkg.sv
/*
 * package of the process alarm unit: register map, field layout, modes.
 * assumes a classic wishbone slave with 32-bit data and byte addresses.
 */
package pau_pkg;
    localparam int NUM_ALM = 4;
    localparam int NUM_EVT = 10;
    localparam int NUM_OUT = 4;
    localparam int NUM_SRC = NUM_ALM + NUM_EVT;
    localparam int VAL_W = 16;
    localparam int ADR_W = 8;
    // per-alarm block: cfg, lim_a, lim_b at stride 0x10
    localparam logic [ADR_W-1:0] ALM_BASE = 8'h00;
    localparam logic [ADR_W-1:0] ALM_STRIDE = 8'h10;
    localparam logic [3:0] OFS_CFG = 4'h0;
    localparam logic [3:0] OFS_LIMA = 4'h4;
    localparam logic [3:0] OFS_LIMB = 4'h8;
    localparam logic [ADR_W-1:0] OUT_BASE = 8'h40;
    localparam logic [ADR_W-1:0] STAT_ADR = 8'h50;
    localparam logic [ADR_W-1:0] OUTSTAT_ADR = 8'h54;
    localparam logic [ADR_W-1:0] ACK_ADR = 8'h58;
    // cfg fields
    localparam int CFG_TYPE_LSB = 0;
    localparam int CFG_LATCH_LSB = 4;
    localparam int CFG_BLOCK_BIT = 6;
    localparam int CFG_ENA_BIT = 7;
    // output route fields: source mask in 13:0, sense bit 16
    localparam int OUT_INV_BIT = 16;
    localparam logic [31:0] CFG_RST = 32'h0000_0000;
    localparam logic [31:0] OUT_RST = 32'h0000_0000;
    // event flag positions
    localparam int EV_SBRK = 0;
    localparam int EV_LBRK = 1;
    localparam int EV_LOAD = 2;
    localparam int EV_MAN = 3;
    localparam int EV_RANGE = 4;
    localparam int EV_RSP = 5;
    localparam int EV_HTR = 6;
    localparam int EV_SSW = 7;
    localparam int EV_PEND = 8;
    localparam int EV_NEW = 9;
    typedef enum logic [2:0] {
        ALM_FS_HIGH, ALM_FS_LOW, ALM_DEV_BAND, ALM_DEV_HIGH,
        ALM_DEV_LOW, ALM_CUR_HIGH, ALM_CUR_LOW
    } pau_type_t;
    typedef enum logic [1:0] {
        LATCH_OFF, LATCH_AUTO, LATCH_MAN
    } pau_latch_t;
endpackage : pau_pkg

//--- hdl/pau_top.sv
/*
 * process alarm unit: four configurable alarms, event flags and output
 * routing with sense, registers over classic wishbone.
 * assumes samples and acknowledge are synchronous to clk_i.
 */
// Implementation choices: the Wishbone slave port and the register addresses.
// How it works
// - four alarm instances each with own type, limits and options
// - any alarms route to any outputs; several may share one output
// - full scale high active when process value above high limit
// - full scale low active when process value below low limit
// - deviation band active when pv minus setpoint outside band
// - deviation high active when pv minus setpoint above level
// - deviation low active when pv minus setpoint below level
// - current alarms compare load current against upper or lower level
// - latching off, auto or manual; latched indication held until ack
// - auto ack remembered during condition, clears when condition goes
// - manual ack ignored during condition; new ack needed afterwards
// - blocking suppresses alarm until condition first seen inactive
// - each output has configurable sense, energised or not on alarm
// - soft alarms only indicate unless grouped onto an output
// - events route and take sense exactly like alarms
// - flags for open-circuit input and loop failure
// - load failure, heater open and switch fail events from power slave
// - flag active while controller is in manual mode
// - flag active while process value is out of range
// - remote setpoint failure flag when no remote signal seen
// - program end event and new alarm event
`timescale 1ns/1ps
module pau_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // measurement samples
    input wire logic sample_valid_i,
    input wire logic signed [15:0] process_value_i,
    input wire logic signed [15:0] setpoint_value_i,
    input wire logic signed [15:0] load_current_i,
    // operator and controller status
    input wire logic alarm_ack_i,
    input wire logic sensor_open_i,
    input wire logic loop_break_i,
    input wire logic manual_mode_i,
    input wire logic pv_over_i,
    input wire logic pv_under_i,
    input wire logic remote_sp_lost_i,
    input wire logic program_end_i,
    // power slave link status
    input wire logic [1:0] power_slave_link_mode_i,
    input wire logic load_fail_i,
    input wire logic heater_open_i,
    input wire logic solid_state_switch_fail_i,
    // relay outputs
    output logic [3:0] relay_o
);
    localparam int NA = pau_pkg::NUM_ALM;
    localparam int NS = pau_pkg::NUM_SRC;
    localparam int NO = pau_pkg::NUM_OUT;
    localparam int W = pau_pkg::VAL_W;

    ////////////////////////////////////////////////////////////////////////
    // bus access
    logic req;
    logic wr_stb;
    logic [31:0] cfg_ff [NA];
    logic [31:0] lima_ff [NA];
    logic [31:0] limb_ff [NA];
    logic [31:0] route_ff [NO];
    logic [NA-1:0] alarm_ff;
    logic [pau_pkg::NUM_EVT-1:0] evt_ff;
    logic [NS-1:0] src;
    logic sw_ack;
    logic [31:0] nxt_rd;

    assign req = cyc_i & stb_i & ~ack_o;
    assign wr_stb = req & we_i;
    assign src = {evt_ff, alarm_ff};
    assign sw_ack = wr_stb && adr_i == pau_pkg::ACK_ADR && sel_i[0]
                    && dat_i[0];

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction : merge

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    always_comb begin
        nxt_rd = 32'h0000_0000;
        for (int i = 0; i < NA; i++) begin
            if (adr_i[7:4] == 4'(i) && adr_i < pau_pkg::OUT_BASE) begin
                unique case (adr_i[3:0])
                    pau_pkg::OFS_CFG: nxt_rd = cfg_ff[i];
                    pau_pkg::OFS_LIMA: nxt_rd = lima_ff[i];
                    pau_pkg::OFS_LIMB: nxt_rd = limb_ff[i];
                    default: nxt_rd = 32'h0000_0000;
                endcase
            end
        end
        for (int o = 0; o < NO; o++) begin
            if (adr_i == pau_pkg::OUT_BASE + 8'(4 * o)) begin
                nxt_rd = route_ff[o];
            end
        end
        if (adr_i == pau_pkg::STAT_ADR) begin
            nxt_rd = 32'(src);
        end
        if (adr_i == pau_pkg::OUTSTAT_ADR) begin
            nxt_rd = 32'(relay_o);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (req && !we_i) begin
            dat_o <= nxt_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sample capture
    logic signed [W-1:0] pv_ff;
    logic signed [W-1:0] sp_ff;
    logic signed [W-1:0] cur_ff;
    logic smp_ff;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pv_ff <= '0;
            sp_ff <= '0;
            cur_ff <= '0;
            smp_ff <= 1'b0;
        end else begin
            smp_ff <= sample_valid_i;
            if (sample_valid_i) begin
                pv_ff <= process_value_i;
                sp_ff <= setpoint_value_i;
                cur_ff <= load_current_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // alarm instances
    logic signed [W:0] dev;
    logic [NA-1:0] cond;
    logic [NA-1:0] ackd_ff;
    logic [NA-1:0] armed_ff;

    assign dev = (W+1)'(pv_ff) - (W+1)'(sp_ff);

    for (genvar i = 0; i < NA; i++) begin : g_alm
        logic signed [W-1:0] la;
        logic signed [W-1:0] lb;
        logic [2:0] typ;
        logic [1:0] lat;
        logic blk;
        logic ena;
        logic raw;
        logic cfg_wr;
        assign la = lima_ff[i][W-1:0];
        assign lb = limb_ff[i][W-1:0];
        assign typ = cfg_ff[i][pau_pkg::CFG_TYPE_LSB +: 3];
        assign lat = cfg_ff[i][pau_pkg::CFG_LATCH_LSB +: 2];
        assign blk = cfg_ff[i][pau_pkg::CFG_BLOCK_BIT];
        assign ena = cfg_ff[i][pau_pkg::CFG_ENA_BIT];
        assign cfg_wr = wr_stb &&
            adr_i == pau_pkg::ALM_BASE + 8'(i) * pau_pkg::ALM_STRIDE;

        always_comb begin
            unique case (typ)
                pau_pkg::ALM_FS_HIGH: raw = pv_ff > la;
                pau_pkg::ALM_FS_LOW: raw = pv_ff < la;
                pau_pkg::ALM_DEV_BAND:
                    raw = dev > (W+1)'(la) || dev < -(W+1)'(la);
                pau_pkg::ALM_DEV_HIGH: raw = dev > (W+1)'(la);
                pau_pkg::ALM_DEV_LOW: raw = dev < (W+1)'(la);
                pau_pkg::ALM_CUR_HIGH: raw = cur_ff > la;
                pau_pkg::ALM_CUR_LOW: raw = cur_ff < lb;
                default: raw = 1'b0;
            endcase
        end
        assign cond[i] = ena & raw;

        always_ff @(posedge clk_i) begin
            if (rst_i || cfg_wr) begin
                armed_ff[i] <= 1'b0;
            end else if (!blk || (smp_ff && !cond[i])) begin
                armed_ff[i] <= 1'b1;
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i || cfg_wr) begin
                alarm_ff[i] <= 1'b0;
                ackd_ff[i] <= 1'b0;
            end else if (cond[i] && armed_ff[i]) begin
                alarm_ff[i] <= 1'b1;
                if ((alarm_ack_i || sw_ack) &&
                    lat == pau_pkg::LATCH_AUTO) begin
                    ackd_ff[i] <= 1'b1;
                end
            end else if (lat == pau_pkg::LATCH_OFF || !armed_ff[i]) begin
                alarm_ff[i] <= 1'b0;
                ackd_ff[i] <= 1'b0;
            end else if (lat == pau_pkg::LATCH_AUTO && ackd_ff[i]) begin
                alarm_ff[i] <= 1'b0;
                ackd_ff[i] <= 1'b0;
            end else if (alarm_ack_i || sw_ack) begin
                alarm_ff[i] <= 1'b0;
                ackd_ff[i] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // event flags
    logic [NA-1:0] alm_q_ff;
    logic newalm;
    assign newalm = |(alarm_ff & ~alm_q_ff);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_ff <= '0;
            alm_q_ff <= '0;
        end else begin
            alm_q_ff <= alarm_ff;
            evt_ff[pau_pkg::EV_SBRK] <= sensor_open_i;
            evt_ff[pau_pkg::EV_LBRK] <= loop_break_i;
            evt_ff[pau_pkg::EV_LOAD] <= load_fail_i &&
                power_slave_link_mode_i == 2'd1;
            evt_ff[pau_pkg::EV_HTR] <= heater_open_i &&
                power_slave_link_mode_i == 2'd2;
            evt_ff[pau_pkg::EV_SSW] <= solid_state_switch_fail_i &&
                power_slave_link_mode_i == 2'd2;
            evt_ff[pau_pkg::EV_MAN] <= manual_mode_i;
            evt_ff[pau_pkg::EV_RANGE] <= pv_over_i | pv_under_i;
            evt_ff[pau_pkg::EV_RSP] <= remote_sp_lost_i;
            evt_ff[pau_pkg::EV_PEND] <= program_end_i;
            if (newalm) begin
                evt_ff[pau_pkg::EV_NEW] <= 1'b1;
            end else if (alarm_ack_i || sw_ack) begin
                evt_ff[pau_pkg::EV_NEW] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration writes
    for (genvar i = 0; i < NA; i++) begin : g_cfg
        logic [7:0] base;
        assign base = pau_pkg::ALM_BASE + 8'(i) * pau_pkg::ALM_STRIDE;
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                cfg_ff[i] <= pau_pkg::CFG_RST;
                lima_ff[i] <= pau_pkg::CFG_RST;
                limb_ff[i] <= pau_pkg::CFG_RST;
            end else if (wr_stb) begin
                if (adr_i == base + 8'(pau_pkg::OFS_CFG)) begin
                    cfg_ff[i] <= merge(cfg_ff[i], dat_i, sel_i)
                                 & 32'h0000_00ff;
                end
                if (adr_i == base + 8'(pau_pkg::OFS_LIMA)) begin
                    lima_ff[i] <= merge(lima_ff[i], dat_i, sel_i)
                                  & 32'h0000_ffff;
                end
                if (adr_i == base + 8'(pau_pkg::OFS_LIMB)) begin
                    limb_ff[i] <= merge(limb_ff[i], dat_i, sel_i)
                                  & 32'h0000_ffff;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output routing
    for (genvar o = 0; o < NO; o++) begin : g_out
        logic hit;
        assign hit = |(route_ff[o][NS-1:0] & src);
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                route_ff[o] <= pau_pkg::OUT_RST;
                relay_o[o] <= 1'b0;
            end else begin
                if (wr_stb && adr_i == pau_pkg::OUT_BASE + 8'(4 * o)) begin
                    route_ff[o] <= merge(route_ff[o], dat_i, sel_i)
                                   & 32'h0001_3fff;
                end
                relay_o[o] <= hit ^ route_ff[o][pau_pkg::OUT_INV_BIT];
            end
        end
    end
endmodule : pau_top

//--- test/pau_operator.sv
/*
 * operator model: turns a bench press into an acknowledge pulse.
 * assumes press_i changes just after a rising edge of clk_i.
 */
`timescale 1ns/1ps
module pau_operator (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bench request
    input wire logic press_i,
    // acknowledge to the unit
    output logic alarm_ack_o
);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            alarm_ack_o <= 1'b0;
        end else begin
            alarm_ack_o <= press_i && !alarm_ack_o;
        end
    end
endmodule : pau_operator

//--- test/pau_properties.sv
/*
 * checker for pau_top: bus handshake, reset and relay status relations.
 * assumes it is bound to pau_top and sees only its ports.
 */
`timescale 1ns/1ps
module pau_properties (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    // relays
    input wire logic [3:0] relay_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////////////////
    sequence s_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence s_rd;
        s_req ##0 !we_i;
    endsequence
    property p_ack_next;
        s_req |=> ack_o;
    endproperty
    property p_ack_idle;
        !(cyc_i && stb_i) |=> !ack_o;
    endproperty
    property p_ack_pulse;
        ack_o |=> !ack_o;
    endproperty
    property p_rd_hold;
        !(cyc_i && stb_i && !we_i && !ack_o) |=> $stable(dat_o);
    endproperty
    property p_unmapped;
        s_rd ##0 adr_i >= 8'h5C |=> dat_o == 32'h0000_0000;
    endproperty
    property p_outstat;
        s_rd ##0 adr_i == 8'h54 |=>
            dat_o[3:0] == relay_o || dat_o[3:0] == $past(relay_o);
    endproperty
    property p_rst_out;
        disable iff (1'b0)
        rst_i |=> !ack_o && relay_o == 4'h0 && dat_o == 32'h0000_0000;
    endproperty
    property p_rst_relay;
        disable iff (1'b0)
        $fell(rst_i) |-> relay_o == 4'h0 ##1 relay_o == 4'h0;
    endproperty
    ////////////////////////////////////////////////////////////////////////
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    a_ack_idle: assert property (p_ack_idle) else $error("stray ack");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
    a_unmapped: assert property (p_unmapped) else $error("unmapped data");
    a_outstat: assert property (p_outstat) else $error("relay status");
    a_rst_out: assert property (p_rst_out) else $error("reset outputs");
    a_rst_relay: assert property (p_rst_relay) else $error("relay");
endmodule : pau_properties
bind pau_top pau_properties u_pau_properties (.clk_i, .rst_i, .cyc_i,
    .stb_i, .we_i, .adr_i, .dat_o, .ack_o, .relay_o);

//--- test/tb.sv
/*
 * bench for pau_top: registers, alarm types, latching, blocking, events.
 * assumes the operator model and the bound checker.
 */
`timescale 1ns/1ps
module tb;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, sv, press, ack, a;
    logic [7:0] adr_i;
    logic [31:0] dat_i, dat_o, rd;
    logic ack_o;
    logic signed [15:0] pv, sp, v;
    logic [9:0] ev;
    logic [1:0] md;
    logic [3:0] rel;
    int fail_count, samples_checked;
    pau_top u_pau_top (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i(4'hF), .dat_i, .dat_o, .ack_o, .sample_valid_i(sv),
        .process_value_i(pv), .setpoint_value_i(sp), .load_current_i(pv),
        .alarm_ack_i(ack), .sensor_open_i(ev[0]), .loop_break_i(ev[1]),
        .load_fail_i(ev[2]), .manual_mode_i(ev[3]), .pv_over_i(ev[4]),
        .remote_sp_lost_i(ev[5]), .heater_open_i(ev[6]),
        .solid_state_switch_fail_i(ev[7]), .program_end_i(ev[8]),
        .pv_under_i(ev[9]), .power_slave_link_mode_i(md), .relay_o(rel));
    pau_operator u_pau_operator (.clk_i, .rst_i, .press_i(press),
        .alarm_ack_o(ack));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [7:0] ad,
            input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= ad;
        dat_i <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (ack_o !== 1'b1) begin
            fail_count++;
            summarize();
        end
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, 8'h50, 32'h0000_0000);
        chk(rd & m, e);
    endtask : st
    task automatic smp(input logic signed [15:0] x);
        pv <= x;
        sv <= 1'b1;
        @(posedge clk_i);
        sv <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : smp
    task automatic pk();
        press <= 1'b1;
        @(posedge clk_i);
        press <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : pk
    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        wb(1'b0, 8'h30, 32'h0000_0000);
        chk(rd, pau_pkg::CFG_RST);
        wb(1'b0, 8'h4C, 32'h0000_0000);
        chk(rd, pau_pkg::OUT_RST);
        wb(1'b1, 8'h34, 32'h0000_1234);
        wb(1'b0, 8'h34, 32'h0000_0000);
        chk(rd, 32'h0000_1234);
        wb(1'b1, 8'h5C, 32'h0000_FFFF);
        wb(1'b0, 8'h5C, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        wb(1'b1, 8'h04, 32'h0000_000A);
        wb(1'b1, 8'h08, 32'h0000_000A);
        wb(1'b1, 8'h40, 32'h0000_0001);
        wb(1'b1, 8'h44, 32'h0001_0001);
        wb(1'b1, 8'h48, 32'h0000_0080);
    endtask : t_regs
    task automatic t_types();
        for (int t = 0; t < 7; t++) begin
            wb(1'b1, 8'h00, 32'h0000_0080 | 32'(t));
            for (int k = 0; k < 3; k++) begin
                v = 16'(20 - 20 * k);
                a = (t == 2) ? (v > 10 || v < -10) :
                    (t == 1 || t == 4 || t == 6) ? v < 10 : v > 10;
                smp(v);
                st(32'h0000_000F, {31'h0, a});
                chk(32'(rel), {28'h0, 2'h0, ~a, a});
                wb(1'b0, 8'h54, 32'h0000_0000);
                chk(rd & 32'h0000_0003, {30'h0, ~a, a});
            end
        end
        wb(1'b1, 8'h00, 32'h0000_0083);
        sp <= 16'sh000F;
        smp(16'sh0014);
        st(32'h0000_000F, 32'h0000_0000);
        sp <= 16'sh0000;
        smp(16'sh0000);
    endtask : t_types
    task automatic t_latch();
        wb(1'b1, 8'h00, 32'h0000_0090);
        smp(16'sh0014);
        smp(16'sh0000);
        st(32'h0000_3FFF, 32'h0000_2001);
        pk();
        st(32'h0000_3FFF, 32'h0000_0000);
        smp(16'sh0014);
        pk();
        smp(16'sh0000);
        st(32'h0000_000F, 32'h0000_0000);
        wb(1'b1, 8'h00, 32'h0000_00A0);
        smp(16'sh0014);
        wb(1'b1, 8'h58, 32'h0000_0001);
        smp(16'sh0000);
        st(32'h0000_000F, 32'h0000_0001);
        pk();
        st(32'h0000_000F, 32'h0000_0000);
    endtask : t_latch
    task automatic t_block();
        smp(16'sh0014);
        wb(1'b1, 8'h00, 32'h0000_00C0);
        smp(16'sh0014);
        st(32'h0000_000F, 32'h0000_0000);
        smp(16'sh0000);
        smp(16'sh0014);
        st(32'h0000_000F, 32'h0000_0001);
    endtask : t_block
    task automatic t_events();
        wb(1'b1, 8'h00, 32'h0000_0000);
        wb(1'b1, 8'h58, 32'h0000_0001);
        for (int k = 0; k < 10; k++) begin
            ev <= 10'(1 << k);
            md <= (k == 2) ? 2'h1 : 2'h2;
            repeat (3) @(posedge clk_i);
            st(32'h0000_3FFF, 32'(1 << (k == 9 ? 8 : k + 4)));
            chk(32'(rel[2]), 32'(k == 3));
        end
        ev <= 10'h004;
        md <= 2'h2;
        repeat (3) @(posedge clk_i);
        st(32'h0000_0040, 32'h0000_0000);
        ev <= 10'h000;
    endtask : t_events
    ////////////////////////////////////////////////////////////////////////
    initial begin
        rst_i = 1'b1;
        {cyc_i, stb_i, we_i, sv, press} = 5'h00;
        adr_i = 8'h00;
        dat_i = 32'h0000_0000;
        {pv, sp} = 32'h0000_0000;
        ev = 10'h000;
        md = 2'h1;
        fail_count = 0;
        samples_checked = 0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_types();
        t_latch();
        t_block();
        t_events();
        summarize();
    end
endmodule : tb
